// ### hw/tac_pkg.sv
package tac_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADC_W = 10;
  localparam int THR_W = 8;
  localparam int CH_W = 3;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int IRQ_W = 4;
  // ----------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_RESULT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h14;
  localparam int CTRL_SHARED_BIT = 0;
  localparam int IRQ_CONV_DONE = 0;
  localparam int IRQ_OVERTEMP = 1;
  localparam int IRQ_BYTE_WR = 2;
  localparam int IRQ_READ_END = 3;
  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [CH_W-1:0] CHAN_TEMP = 3'h0;
  localparam logic [CH_W-1:0] CHAN_BANDGAP = 3'h7;
  localparam logic [CH_W-1:0] CHAN_RESET = 3'h0;
  localparam logic [THR_W-1:0] THR_RESET = 8'h99;
  localparam logic CTRL_SHARED_RESET = 1'b0;
  localparam logic [CNT_W-1:0] READ_BITS = 4'hA;
  localparam logic [CNT_W-1:0] WRITE_LAST = 4'h7;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int CONV_TIME_NS = 8000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } tac_bus_req_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } tac_edge_t;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_READ = 2'b01,
    SER_WRITE = 2'b10
  } tac_ser_state_t;

  typedef enum logic {
    CV_TRACK = 1'b0,
    CV_CONVERT = 1'b1
  } tac_conv_state_t;
endpackage

// ### hw/tac_sync.sv
`timescale 1ns/1ns
`default_nettype none
module tac_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Asynchronous pin and its sampled view
  input wire logic pin,
  output tac_pkg::tac_edge_t sig
);
  import tac_pkg::*;

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  // ----------------------------------------------------------------
  // Three stage sampler, a change counts once stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

  always_comb begin
    sig.level = level_q;
    sig.rise = (s2_q == s3_q) && s3_q && !level_q;
    sig.fall = (s2_q == s3_q) && !s3_q && level_q;
  end
endmodule
`default_nettype wire

// ### hw/tac_conv.sv
`timescale 1ns/1ns
`default_nettype none
module tac_conv #(
  parameter int CYCLES = tac_pkg::CONV_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Start and analog result
  input wire logic start,
  input wire logic [tac_pkg::ADC_W-1:0] adc_data,
  // Sequencer state
  output logic busy,
  output logic hold,
  output logic done,
  output logic [tac_pkg::ADC_W-1:0] result
);
  import tac_pkg::*;

  tac_conv_state_t state_q;
  logic [15:0] cnt_q;
  logic done_q;
  logic [ADC_W-1:0] result_q;

  // ----------------------------------------------------------------
  // Conversion timer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= CV_TRACK;
      cnt_q <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        CV_TRACK: begin
          if (start) begin
            state_q <= CV_CONVERT;
            cnt_q <= 16'(CYCLES - 1);
          end
        end
        CV_CONVERT: begin
          if (cnt_q == 16'h0000) begin
            state_q <= CV_TRACK;
            done_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: state_q <= CV_TRACK;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      result_q <= 10'h000;
    end else if (state_q == CV_CONVERT && cnt_q == 16'h0000) begin
      result_q <= adc_data;
    end
  end

  assign busy = (state_q == CV_CONVERT);
  assign hold = (state_q == CV_CONVERT);
  assign done = done_q;
  assign result = result_q;
endmodule
`default_nettype wire

// ### hw/tac_top.sv
// Summary of operation
// - Start falling edge begins conversion, enters hold
// - Conversion end returns track/hold to track
// - Start low at conversion end powers down
// - Temperature result above threshold drives flag low
// - Read/write select rising edge releases flag
// - Data out on falling, in on rising
// - Output floats on select fall or port-select rise; the shared pin ignores port select and floats on select fall only
// - Shared pin carries data both ways
// - Written channel register picks converted input
// - Byte decode: channel or threshold register
// - Channel codes; channel resets to temperature
// - Compare upper eight result bits to threshold
// - Busy output high throughout each conversion
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module tac_top #(
  parameter int CONV_CYCLES = tac_pkg::CONV_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire tac_pkg::tac_bus_req_t bus_req,
  output logic [tac_pkg::DATA_W-1:0] bus_rdata,
  output logic irq,
  // Conversion control pins
  input wire logic conv_start_n,
  output logic busy,
  output logic overtemp_flag_n,
  // Serial port pins
  input wire logic sclk,
  input wire logic rd_wr,
  input wire logic port_sel_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  // Analog core
  input wire logic [tac_pkg::ADC_W-1:0] adc_data,
  output logic [tac_pkg::CH_W-1:0] chan_sel,
  output logic track_hold,
  output logic power_down
);
  import tac_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic tac_is_chan_byte(input logic [BYTE_W-1:0] b);
    tac_is_chan_byte = (b[BYTE_W-1:CH_W] == 5'h00);
  endfunction

  function automatic logic tac_hit(input tac_bus_req_t r, input logic [ADDR_W-1:0] a);
    tac_hit = (r.addr == a);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tac_edge_t cs_e;
  tac_edge_t sclk_e;
  tac_edge_t rw_e;
  tac_edge_t ps_e;
  tac_edge_t dat_e;
  logic shared_q;
  logic data_pin;
  logic port_en;
  logic conv_busy;
  logic conv_hold;
  logic conv_done;
  logic [ADC_W-1:0] conv_result;
  logic [CH_W-1:0] chan_q;
  logic [CH_W-1:0] conv_chan_q;
  logic [THR_W-1:0] thr_q;
  logic ot_q;
  logic pd_q;
  tac_ser_state_t ser_q;
  logic [ADC_W-1:0] rsh_q;
  logic [BYTE_W-1:0] wsh_q;
  logic [CNT_W-1:0] cnt_q;
  logic byte_done;
  logic [BYTE_W-1:0] byte_val;
  logic read_start;
  logic read_end;
  logic ot_set;
  logic ot_rel;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_ev;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;

  // ----------------------------------------------------------------
  // Pin samplers
  // ----------------------------------------------------------------
  assign data_pin = shared_q ? sdio_i : din;

  tac_sync u_sync_cs (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin(conv_start_n),
    .sig(cs_e)
  );

  tac_sync u_sync_sclk (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin(sclk),
    .sig(sclk_e)
  );

  tac_sync u_sync_rw (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin(rd_wr),
    .sig(rw_e)
  );

  tac_sync u_sync_ps (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin(port_sel_n),
    .sig(ps_e)
  );

  tac_sync u_sync_dat (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin(data_pin),
    .sig(dat_e)
  );

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  tac_conv #(
    .CYCLES(CONV_CYCLES)
  ) u_conv (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(cs_e.fall),
    .adc_data(adc_data),
    .busy(conv_busy),
    .hold(conv_hold),
    .done(conv_done),
    .result(conv_result)
  );

  assign busy = conv_busy;
  assign track_hold = conv_hold;
  assign chan_sel = chan_q;

  // Channel checked by the overtemperature flag is frozen for the whole conversion; chan_sel follows chan_q
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      conv_chan_q <= CHAN_RESET;
    end else if (cs_e.fall && !conv_busy) begin
      conv_chan_q <= chan_q;
    end
  end

  // ----------------------------------------------------------------
  // Power down
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pd_q <= 1'b0;
    end else if (conv_done && !cs_e.level) begin
      pd_q <= 1'b1;
    end else if (cs_e.rise) begin
      pd_q <= 1'b0;
    end
  end

  assign power_down = pd_q;

  // ----------------------------------------------------------------
  // Overtemperature flag
  // ----------------------------------------------------------------
  assign ot_set = conv_done && (conv_chan_q == CHAN_TEMP)
                  && (conv_result[ADC_W-1:ADC_W-THR_W] > thr_q);
  assign ot_rel = (conv_done && (conv_chan_q == CHAN_TEMP) && !ot_set) || read_start;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ot_q <= 1'b0;
    end else if (ot_set) begin
      ot_q <= 1'b1;
    end else if (ot_rel) begin
      ot_q <= 1'b0;
    end
  end

  assign overtemp_flag_n = !ot_q;

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  assign port_en = shared_q || !ps_e.level;
  assign read_start = rw_e.rise && port_en;
  assign read_end = (ser_q == SER_READ)
                    && (rw_e.fall || (!shared_q && ps_e.rise));
  assign byte_done = (ser_q == SER_WRITE) && port_en && sclk_e.rise
                     && !rw_e.level && (cnt_q == WRITE_LAST);
  assign byte_val = {wsh_q[BYTE_W-2:0], dat_e.level};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ser_q <= SER_IDLE;
    end else if (read_start) begin
      ser_q <= SER_READ;
    end else begin
      case (ser_q)
        SER_IDLE: begin
          if (port_en && !rw_e.level) begin
            ser_q <= SER_WRITE;
          end
        end
        SER_READ: begin
          if (read_end) begin
            ser_q <= SER_IDLE;
          end
        end
        SER_WRITE: begin
          if (!port_en || rw_e.level) begin
            ser_q <= SER_IDLE;
          end
        end
        default: ser_q <= SER_IDLE;
      endcase
    end
  end

  // Bit counter shared by both directions
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
    end else if (read_start || ser_q == SER_IDLE) begin
      cnt_q <= 4'h0;
    end else if (ser_q == SER_READ && port_en && sclk_e.fall && cnt_q != READ_BITS) begin
      cnt_q <= cnt_q + 4'h1;
    end else if (ser_q == SER_WRITE && port_en && sclk_e.rise && !rw_e.level) begin
      cnt_q <= (cnt_q == WRITE_LAST) ? 4'h0 : cnt_q + 4'h1;
    end
  end

  // Read shifter, MSB presented first and advanced on falling clock
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rsh_q <= 10'h000;
    end else if (read_start) begin
      rsh_q <= conv_result;
    end else if (ser_q == SER_READ && port_en && sclk_e.fall) begin
      rsh_q <= {rsh_q[ADC_W-2:0], 1'b0};
    end
  end

  // Write shifter, captured on rising clock
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wsh_q <= 8'h00;
    end else if (ser_q == SER_WRITE && port_en && sclk_e.rise && !rw_e.level) begin
      wsh_q <= byte_val;
    end
  end

  // Control byte decode
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      chan_q <= CHAN_RESET;
    end else if (byte_done && tac_is_chan_byte(byte_val)) begin
      chan_q <= byte_val[CH_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      thr_q <= THR_RESET;
    end else if (byte_done && !tac_is_chan_byte(byte_val)) begin
      thr_q <= byte_val;
    end
  end

  // Output drivers float outside a read
  always_comb begin
    dout = rsh_q[ADC_W-1];
    sdio_o = rsh_q[ADC_W-1];
    dout_oe = (ser_q == SER_READ) && !shared_q && !ps_e.level && rw_e.level;
    sdio_oe = (ser_q == SER_READ) && shared_q && rw_e.level;
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_comb begin
    irq_ev = '0;
    irq_ev[IRQ_CONV_DONE] = conv_done;
    irq_ev[IRQ_OVERTEMP] = ot_set;
    irq_ev[IRQ_BYTE_WR] = byte_done;
    irq_ev[IRQ_READ_END] = read_end;
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
    end else if (bus_req.wr && tac_hit(bus_req, REG_IRQ_STAT)) begin
      irq_stat_q <= (irq_stat_q & ~bus_req.wdata[IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat_q <= irq_stat_q | irq_ev;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_mask_q <= '0;
    end else if (bus_req.wr && tac_hit(bus_req, REG_IRQ_MASK)) begin
      irq_mask_q <= bus_req.wdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      shared_q <= CTRL_SHARED_RESET;
    end else if (bus_req.wr && tac_hit(bus_req, REG_CTRL)) begin
      shared_q <= bus_req.wdata[CTRL_SHARED_BIT];
    end
  end

  always_comb begin
    rdata_d = '0;
    if (bus_req.rd) begin
      case (bus_req.addr)
        REG_CTRL: rdata_d[CTRL_SHARED_BIT] = shared_q;
        REG_STATUS: rdata_d = {8'h00, ser_q == SER_READ, ser_q == SER_WRITE,
                               chan_q, ot_q, pd_q, conv_busy};
        REG_RESULT: rdata_d[ADC_W-1:0] = conv_result;
        REG_CONFIG: rdata_d = {5'h00, chan_q, thr_q};
        REG_IRQ_STAT: rdata_d[IRQ_W-1:0] = irq_stat_q;
        REG_IRQ_MASK: rdata_d[IRQ_W-1:0] = irq_mask_q;
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata = rdata_q;
endmodule
`default_nettype wire

// ### testbench/tac_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
module tac_top_sva #(
  parameter int CONV_CYCLES = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire tac_pkg::tac_bus_req_t bus_req,
  input wire logic [tac_pkg::DATA_W-1:0] bus_rdata,
  // Conversion pins
  input wire logic conv_start_n,
  input wire logic busy,
  input wire logic overtemp_flag_n,
  input wire logic track_hold,
  input wire logic power_down,
  // Serial pins
  input wire logic rd_wr,
  input wire logic port_sel_n,
  input wire logic dout_oe,
  input wire logic sdio_oe
);
  import tac_pkg::*;
  logic [15:0] cnt_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Busy cycle counter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n || !busy) begin
      cnt_q <= 16'h0;
    end else begin
      cnt_q <= cnt_q + 16'h1;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  conv_len_a: assert property ($fell(busy) |-> cnt_q == CONV_CYCLES)
    else $error("busy length wrong");
  hold_busy_a: assert property (track_hold == busy)
    else $error("track hold not with busy");
  start_edge_a: assert property ($fell(conv_start_n) && !busy |-> ##[2:5] busy)
    else $error("start edge missed");
  pd_set_a: assert property ($fell(busy) && !conv_start_n && !$past(conv_start_n, 4)
    |=> power_down)
    else $error("no power down");
  ot_set_a: assert property ($fell(overtemp_flag_n) |-> !$past(busy) && $past(busy, 2))
    else $error("flag set outside conversion end");
  ot_clr_a: assert property ($rose(rd_wr) && !port_sel_n && !busy
    |-> ##[2:6] overtemp_flag_n)
    else $error("flag not released");
  out_float_a: assert property ($fell(rd_wr) || $rose(port_sel_n) |-> ##[1:6] !dout_oe)
    else $error("output not floated");
  sel_idle_a: assert property (port_sel_n [*6] |-> !dout_oe)
    else $error("output driven while deselected");
  sdio_dir_a: assert property (!rd_wr [*7] |-> !sdio_oe)
    else $error("shared pin driven outside read");
  rdata_idle_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 16'h0)
    else $error("read data outside slot");
  cover property ($fell(busy) && power_down);
  cover property ($fell(overtemp_flag_n));
  cover property ($rose(sdio_oe));
endmodule
`default_nettype wire

// ### testbench/tac_host.sv
`timescale 1ns/1ns
`default_nettype none
module tac_host (
  // Link pins
  output var logic sclk,
  output var logic rd_wr,
  output var logic port_sel_n,
  output var logic din,
  output var logic h_o,
  output var logic h_oe,
  // Lines seen
  input wire logic shared,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic sdio
);
  initial begin
    sclk = 1'b0;
    rd_wr = 1'b0;
    port_sel_n = 1'b1;
    din = 1'b0;
    h_o = 1'b0;
    h_oe = 1'b0;
  end
  // ----------------------------------------------------------------
  // Transfers, clock idles low between frames
  // ----------------------------------------------------------------
  task automatic put_byte(input logic [7:0] b);
    #7;
    port_sel_n = 1'b0;
    rd_wr = 1'b0;
    h_oe = shared;
    #160;
    for (int i = 7; i >= 0; i--) begin
      if (shared) h_o = b[i];
      else din = b[i];
      #160;
      sclk = 1'b1;
      #160;
      sclk = 1'b0;
    end
    #160;
    h_oe = 1'b0;
    din = ~din;
    port_sel_n = 1'b1;
    #320;
  endtask
  task automatic get_word(output logic [9:0] v);
    #7;
    port_sel_n = 1'b0;
    // Port selected first, so the read edge meets an enabled port
    #160;
    rd_wr = 1'b1;
    #320;
    for (int i = 9; i >= 0; i--) begin
      sclk = 1'b1;
      v[i] = shared ? sdio : (dout_oe ? dout : ~dout);
      #160;
      sclk = 1'b0;
      #160;
    end
    rd_wr = 1'b0;
    port_sel_n = 1'b1;
    #320;
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import tac_pkg::*;
  typedef struct packed {logic mode; logic [7:0] b; logic [10:0] cfg;} tac_row_t;
  localparam int NCONV = 8;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  tac_bus_req_t bus_req;
  logic [DATA_W-1:0] bus_rdata;
  logic irq, busy, overtemp_flag_n, dout, dout_oe, sdio_o, sdio_oe, track_hold, power_down;
  logic conv_start_n, sclk, rd_wr, port_sel_n, din, h_o, h_oe, shared;
  logic [ADC_W-1:0] adc_data;
  logic [CH_W-1:0] chan_sel;
  wire logic sdio_w;
  int n_errors = 0;
  int checks = 0;
  logic [15:0] rd_q;
  logic [9:0] word;
  tac_row_t rows [6] = '{'{1'b0, 8'h03, 11'h399}, '{1'b1, 8'h08, 11'h308},
    '{1'b0, 8'h07, 11'h708}, '{1'b1, 8'h04, 11'h408}, '{1'b0, 8'h99, 11'h499},
    '{1'b1, 8'h00, 11'h099}};
  logic [9:0] adcs [2] = '{10'h267, 10'h268};
  always #20 core_clk = ~core_clk;
  // Released shared line shows the inverse of the last value
  assign sdio_w = sdio_oe ? sdio_o : (h_oe ? h_o : ~h_o);
  tac_top #(.CONV_CYCLES(NCONV)) u_tac_top (.core_clk(core_clk), .rst_n(rst_n),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .irq(irq), .conv_start_n(conv_start_n),
    .busy(busy), .overtemp_flag_n(overtemp_flag_n), .sclk(sclk), .rd_wr(rd_wr),
    .port_sel_n(port_sel_n), .din(din), .dout(dout), .dout_oe(dout_oe), .sdio_i(sdio_w),
    .sdio_o(sdio_o), .sdio_oe(sdio_oe), .adc_data(adc_data), .chan_sel(chan_sel),
    .track_hold(track_hold), .power_down(power_down));
  tac_host u_tac_host (.sclk(sclk), .rd_wr(rd_wr), .port_sel_n(port_sel_n), .din(din),
    .h_o(h_o), .h_oe(h_oe), .shared(shared), .dout(dout), .dout_oe(dout_oe), .sdio(sdio_w));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask
  task automatic bus_rd(input logic [7:0] a);
    @(posedge core_clk);
    bus_req <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1;
    rd_q = bus_rdata;
  endtask
  task automatic set_mode(input logic m);
    bus_wr(REG_CTRL, {15'h0, m});
    shared = m;
    @(posedge core_clk);
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(busy, lvl);
  endtask
  task automatic conv(input logic [9:0] adc, input logic low, input logic exp_n);
    @(posedge core_clk);
    adc_data <= adc;
    conv_start_n <= 1'b0;
    wait_busy(1'b1);
    chk(track_hold, 1'b1);
    @(posedge core_clk);
    conv_start_n <= ~low;
    wait_busy(1'b0);
    @(posedge core_clk);
    #1;
    chk(track_hold, 1'b0);
    chk(overtemp_flag_n, exp_n);
    chk(power_down, low);
    bus_rd(REG_RESULT);
    chk(rd_q, {6'h0, adc});
    @(posedge core_clk);
    conv_start_n <= 1'b1;
  endtask
  task automatic give_verdict();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    bus_req = '{8'h0, 16'h0, 1'b0, 1'b0};
    conv_start_n = 1'b1;
    adc_data = 10'h0;
    shared = 1'b0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    chk(chan_sel, CHAN_RESET);
    bus_rd(REG_CONFIG);
    chk(rd_q, 16'h0099);
    bus_rd(8'h20);
    chk(rd_q, 16'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      set_mode(rows[i].mode);
      u_tac_host.put_byte(rows[i].b);
      bus_rd(REG_CONFIG);
      chk(rd_q, {5'h0, rows[i].cfg});
      chk(chan_sel, rows[i].cfg[10:8]);
    end
    $display("control byte test done");
    bus_wr(REG_IRQ_MASK, 16'h0001);
    conv(10'h3FF, 1'b0, 1'b0);
    chk(irq, 1'b1);
    bus_wr(REG_IRQ_STAT, 16'h000F);
    chk(irq, 1'b0);
    bus_wr(REG_IRQ_MASK, 16'h0000);
    conv(10'h3FF, 1'b0, 1'b0);
    chk(irq, 1'b0);
    bus_wr(REG_IRQ_MASK, 16'h000F);
    chk(irq, 1'b1);
    bus_wr(REG_IRQ_STAT, 16'h000F);
    chk(irq, 1'b0);
    $display("interrupt test done");
    foreach (adcs[i]) begin
      conv(adcs[i], 1'b0, !(adcs[i][9:2] > 8'h99));
    end
    set_mode(1'b0);
    u_tac_host.get_word(word);
    chk(word, 10'h268);
    chk(overtemp_flag_n, 1'b1);
    set_mode(1'b1);
    u_tac_host.get_word(word);
    chk(word, 10'h268);
    $display("serial read test done");
    u_tac_host.put_byte(8'h01);
    conv(10'h3FF, 1'b1, 1'b1);
    repeat (6) @(posedge core_clk);
    #1;
    chk(power_down, 1'b0);
    $display("power down test done");
    give_verdict();
  end
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end
endmodule
bind tac_top tac_top_sva #(.CONV_CYCLES(CONV_CYCLES)) u_tac_top_sva (.core_clk(core_clk),
  .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata), .conv_start_n(conv_start_n),
  .busy(busy), .overtemp_flag_n(overtemp_flag_n), .track_hold(track_hold),
  .power_down(power_down), .rd_wr(rd_wr), .port_sel_n(port_sel_n), .dout_oe(dout_oe),
  .sdio_oe(sdio_oe));
`default_nettype wire
